// >>> rtl/dacm_pkg.sv
package dacm_pkg;
   localparam int CA_W = 24;
   localparam int CLK_NS = 100;
   // grade index: 0 = 2666, 1 = 2933, 2 = 3200
   localparam int PL_TAB[3] = '{5, 6, 6};
   localparam int ALERT_PW_MIN_TAB[3] = '{80, 88, 96};
   localparam int ALERT_PW_MAX_TAB[3] = '{160, 176, 192};
   localparam int ALERT_RSP_TAB[3] = '{71, 78, 85};
   localparam int CAL_TAB[3] = '{5, 6, 6};
   localparam int CALG_TAB[3] = '{6, 8, 8};
   localparam int TMOD_CK = 24;
   localparam int TMOD_NS = 15;
   localparam int TMOD_CYC = (TMOD_NS + CLK_NS - 1) / CLK_NS > TMOD_CK ?
      (TMOD_NS + CLK_NS - 1) / CLK_NS : TMOD_CK;
   localparam int PAR_ON_EXTRA_NS = 6;
   localparam int CT_ENABLE_NS = 200;
   localparam int CT_ENABLE_CYC = (CT_ENABLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CT_VALID_NS = 200;
   localparam int CT_VALID_CYC = CT_VALID_NS / CLK_NS;
   localparam int CTCKE_NS = 10;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] IST_OFS = 8'h08;
   localparam logic [7:0] IMSK_OFS = 8'h0C;
   localparam logic [7:0] LCMD_OFS = 8'h10;
   localparam int CTL_CAL = 0;
   localparam int CTL_GEAR = 1;
   localparam int CTL_PAR = 2;
   localparam int CTL_PERS = 3;
   localparam int CTL_MPSM = 4;
   localparam int CTL_W = 5;
   localparam logic [CTL_W-1:0] CTRL_RST = 5'h04;
   localparam int EV_PAR = 0;
   localparam int EV_MPSM = 1;
   localparam int EV_CT = 2;
   localparam int EV_W = 3;
   typedef struct packed {
      logic cs_n;
      logic ten;
      logic cke;
      logic par;
      logic [CA_W-1:0] ca;
   } dacm_pins_s;
   typedef struct packed {
      logic valid;
      logic [CA_W-1:0] ca;
   } dacm_cmd_s;
   typedef enum logic [1:0] {
      AL_IDLE = 2'b00,
      AL_WAIT = 2'b01,
      AL_PULSE = 2'b10
   } dacm_alert_e;
endpackage

// >>> rtl/dacm_core.sv
`timescale 1ns/1ns
module dacm_core import dacm_pkg::*; #(
   parameter int GRADE = 2,
   parameter int TCPDED_CK = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic irq,
   input wire dacm_pins_s pins,
   output logic alert_n,
   output logic ct_out,
   output dacm_cmd_s cmd
);
   localparam int PL = PL_TAB[GRADE];
   localparam int CAL = CAL_TAB[GRADE];
   localparam int CALG = CALG_TAB[GRADE];
   localparam int PW = ALERT_PW_MIN_TAB[GRADE];
   localparam int MPED = TMOD_CYC + TCPDED_CK;
   localparam int PL1 = PL - 1;

   dacm_pins_s s1_ff, s2_ff;
   dacm_cmd_s cmd_ff;
   dacm_alert_e al_ff;
   logic [7:0] al_cnt_ff;
   logic alert_n_ff, ct_out_ff, irq_ff, pready_ff, pslverr_ff;
   logic [31:0] prdata_ff, rd_mux;
   logic [CTL_W-1:0] ctrl_ff;
   logic [EV_W-1:0] ist_ff, imsk_ff, ev;
   logic pend_ff, cmd_dis_ff, ct_mode_ff;
   logic [3:0] pcnt_ff, lat;
   logic [7:0] mcnt_ff;
   logic [2:0] tcnt_ff;
   logic cs_lo, cap, err, acc, wr, hit;

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;
   assign irq = irq_ff;
   assign alert_n = alert_n_ff;
   assign ct_out = ct_out_ff;
   assign cmd = cmd_ff;

   // pins are asynchronous to clk; only s2_ff is looked at
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= '{cs_n: 1'b1, default: '0};
         s2_ff <= '{cs_n: 1'b1, default: '0};
      end else begin
         s1_ff <= pins;
         s2_ff <= s1_ff;
      end
   end

   assign cs_lo = !s2_ff.cs_n;
   assign lat = ctrl_ff[CTL_GEAR] ? 4'(CALG) : 4'(CAL);
   // capture point: select cycle itself, or lat cycles later with latency on
   assign cap = (ctrl_ff[CTL_CAL] ? (pend_ff && pcnt_ff == lat) : cs_lo)
      && !cmd_dis_ff && !ct_mode_ff && al_ff == AL_IDLE;
   assign err = cap && ctrl_ff[CTL_PAR] && ^{s2_ff.ca, s2_ff.par};

   always_ff @(posedge clk) begin
      if (rst) begin
         pend_ff <= 1'b0;
         pcnt_ff <= 4'h0;
      end else if (pend_ff) begin
         pend_ff <= pcnt_ff != lat;
         pcnt_ff <= pcnt_ff + 4'h1;
      end else if (cs_lo && ctrl_ff[CTL_CAL]) begin
         pend_ff <= 1'b1;
         pcnt_ff <= 4'h1;
      end
   end

   // commands ahead of a parity error are still executed
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_ff <= '0;
      end else begin
         cmd_ff.valid <= cap && !err;
         cmd_ff.ca <= cap ? s2_ff.ca : cmd_ff.ca;
      end
   end

   // alert sequencer; a second error during wait or pulse is not retriggered
   always_ff @(posedge clk) begin
      if (rst) begin
         al_ff <= AL_IDLE;
         al_cnt_ff <= 8'h00;
         alert_n_ff <= 1'b1;
      end else begin
         unique case (al_ff)
            AL_IDLE: if (err) begin
               al_ff <= AL_WAIT;
               al_cnt_ff <= 8'h01;
            end
            AL_WAIT: if (al_cnt_ff == 8'(PL1)) begin
               al_ff <= AL_PULSE;
               al_cnt_ff <= 8'h01;
               alert_n_ff <= 1'b0;
            end else begin
               al_cnt_ff <= al_cnt_ff + 8'h01;
            end
            AL_PULSE: if (al_cnt_ff == 8'(PW)) begin
               al_ff <= AL_IDLE;
               alert_n_ff <= 1'b1;
            end else begin
               al_cnt_ff <= al_cnt_ff + 8'h01;
            end
            default: begin
               al_ff <= AL_IDLE;
               alert_n_ff <= 1'b1;
            end
         endcase
      end
   end

   // power saving: path stays live until the full entry delay has run
   always_ff @(posedge clk) begin
      if (rst || !ctrl_ff[CTL_MPSM]) begin
         mcnt_ff <= 8'h00;
         cmd_dis_ff <= 1'b0;
      end else if (mcnt_ff < 8'(MPED)) begin
         mcnt_ff <= mcnt_ff + 8'h01;
      end else begin
         cmd_dis_ff <= 1'b1;
      end
   end

   // test mode: enable time is counted on the synchronised pin
   always_ff @(posedge clk) begin
      if (rst || !s2_ff.ten) begin
         tcnt_ff <= 3'h0;
         ct_mode_ff <= 1'b0;
         ct_out_ff <= 1'b0;
      end else begin
         if (tcnt_ff < 3'(CT_ENABLE_CYC))
            tcnt_ff <= tcnt_ff + 3'h1;
         if (cs_lo && tcnt_ff >= 3'(CT_ENABLE_CYC))
            ct_mode_ff <= 1'b1;
         ct_out_ff <= (ct_mode_ff || cs_lo) && ^s2_ff.ca;
      end
   end

   // register slave, one wait state so every answer is registered
   assign acc = psel && penable;
   assign wr = acc && pready_ff && pwrite;
   assign hit = paddr inside {CTRL_OFS, STAT_OFS, IST_OFS, IMSK_OFS, LCMD_OFS};

   // previous levels: test-mode and path-off status events are one-cycle pulses on a rise only
   logic ct_mode_d_ff, cmd_dis_d_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         ct_mode_d_ff <= 1'b0;
         cmd_dis_d_ff <= 1'b0;
      end else begin
         ct_mode_d_ff <= ct_mode_ff;
         cmd_dis_d_ff <= cmd_dis_ff;
      end
   end

   assign ev = {ct_mode_ff && !ct_mode_d_ff, cmd_dis_ff && mcnt_ff == 8'(MPED)
      && !cmd_dis_d_ff, err};

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         CTRL_OFS: rd_mux[CTL_W-1:0] = ctrl_ff;
         STAT_OFS: rd_mux[2:0] = {ct_mode_ff, cmd_dis_ff, !alert_n_ff};
         IST_OFS: rd_mux[EV_W-1:0] = ist_ff;
         IMSK_OFS: rd_mux[EV_W-1:0] = imsk_ff;
         LCMD_OFS: rd_mux[CA_W-1:0] = cmd_ff.ca;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= acc && !pready_ff;
         pslverr_ff <= acc && !pready_ff && !hit;
         prdata_ff <= (acc && !pready_ff && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // non-persistent parity: an error switches checking off
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr && paddr == CTRL_OFS) begin
         ctrl_ff <= pwdata[CTL_W-1:0];
      end else if (err && !ctrl_ff[CTL_PERS]) begin
         ctrl_ff[CTL_PAR] <= 1'b0;
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         ist_ff <= '0;
         imsk_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         ist_ff <= (ist_ff & ~((wr && paddr == IST_OFS) ? pwdata[EV_W-1:0] : '0)) | ev;
         if (wr && paddr == IMSK_OFS)
            imsk_ff <= pwdata[EV_W-1:0];
         irq_ff <= |(ist_ff & imsk_ff);
      end
   end

   // checking helpers
   logic [7:0] lo_cnt_ff;
   logic [3:0] since_cs_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         lo_cnt_ff <= 8'h00;
         since_cs_ff <= 4'h0;
      end else begin
         lo_cnt_ff <= alert_n_ff ? 8'h00 : lo_cnt_ff + 8'h01;
         since_cs_ff <= (cs_lo && !pend_ff) ? 4'h0 : since_cs_ff + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   alert_width_a: assert property ($rose(alert_n_ff) |-> lo_cnt_ff == 8'(PW))
      else $error("alert pulse width wrong");
   alert_bound_a: assert property (lo_cnt_ff <= 8'(ALERT_PW_MAX_TAB[GRADE]))
      else $error("alert pulse too long");
   alert_delay_a: assert property (err
      |-> ##[PL:PL] (!alert_n_ff && $past(alert_n_ff)))
      else $error("alert not asserted at parity latency");
   cal_take_a: assert property (cmd_ff.valid && ctrl_ff[CTL_CAL] && !ctrl_ff[CTL_GEAR]
      && $stable(ctrl_ff) |-> since_cs_ff == 4'(CAL))
      else $error("command taken off latency");
   gear_take_a: assert property (cmd_ff.valid && ctrl_ff[CTL_CAL] && ctrl_ff[CTL_GEAR]
      && $stable(ctrl_ff) |-> since_cs_ff == 4'(CALG))
      else $error("gear-down command taken off latency");
   path_off_a: assert property ($rose(cmd_dis_ff) |-> mcnt_ff == 8'(MPED))
      else $error("command path disabled early");
   no_cmd_dis_a: assert property (cmd_dis_ff |-> ##1 !cmd_ff.valid)
      else $error("command executed with path disabled");
   ct_enter_a: assert property ($rose(ct_mode_ff)
      |-> $past(tcnt_ff) >= 3'(CT_ENABLE_CYC))
      else $error("test mode entered too soon");
   ct_valid_a: assert property (ct_mode_ff && s2_ff.ten
      |=> ct_out_ff == ^$past(s2_ff.ca))
      else $error("test output not valid");
   par_block_a: assert property (!alert_n_ff |=> !cmd_ff.valid)
      else $error("command executed during alert");
   alert_idle_a: assert property (al_ff == AL_IDLE |-> alert_n_ff)
      else $error("alert low while sequencer idle");
   cap_ca_a: assert property (cap |=> cmd_ff.ca == $past(s2_ff.ca))
      else $error("captured address wrong");
   ca_hold_a: assert property (!cap |=> $stable(cmd_ff.ca))
      else $error("last command address not held");
   ct_block_a: assert property (ct_mode_ff |=> !cmd_ff.valid)
      else $error("command executed in test mode");
   tcnt_top_a: assert property (tcnt_ff <= 3'(CT_ENABLE_CYC))
      else $error("test enable counter overran");
   path_clear_a: assert property (!ctrl_ff[CTL_MPSM] |=> !cmd_dis_ff)
      else $error("command path off outside power saving");

   // parity mode handling
   pers_keep_a: assert property (err && ctrl_ff[CTL_PERS] && !wr |=> ctrl_ff[CTL_PAR])
      else $error("persistent parity switched off");
   nonpers_off_a: assert property (err && !ctrl_ff[CTL_PERS] && !wr |=> !ctrl_ff[CTL_PAR])
      else $error("parity checking left on after error");
   par_sticky_a: assert property (err |=> ist_ff[EV_PAR])
      else $error("parity event not recorded");

   // bus answer and interrupt
   rdy_pulse_a: assert property (pready_ff |=> !pready_ff)
      else $error("ready longer than one cycle");
   rdy_answer_a: assert property (psel && penable && !pready_ff |=> pready_ff)
      else $error("ready missing after wait state");
   slverr_a: assert property (pslverr_ff |-> pready_ff)
      else $error("error response without ready");
   rdata_zero_a: assert property (!pready_ff |-> prdata_ff == 32'h0000_0000)
      else $error("read data outside answer cycle");
   irq_on_a: assert property (|(ist_ff & imsk_ff) |=> irq_ff)
      else $error("interrupt missing");
   irq_off_a: assert property (!(|(ist_ff & imsk_ff)) |=> !irq_ff)
      else $error("interrupt without unmasked event");

   alert_seen_c: cover property (err ##[1:20] !alert_n_ff);
   cal_cmd_c: cover property (cmd_ff.valid && ctrl_ff[CTL_CAL] && !ctrl_ff[CTL_GEAR]);
   gear_cmd_c: cover property (cmd_ff.valid && ctrl_ff[CTL_CAL] && ctrl_ff[CTL_GEAR]);
   mpsm_c: cover property ($rose(cmd_dis_ff));
   ct_c: cover property ($rose(ct_mode_ff));
endmodule

// >>> tb/dacm_ctl_model.sv
`timescale 1ns/1ns
module dacm_ctl_model import dacm_pkg::*; (
   input wire logic clk,
   output dacm_pins_s pins
);
   initial pins = '{cs_n: 1'b1, ten: 1'b0, cke: 1'b1, par: 1'b0, ca: '0};
   // ca stays put through the latency window, then is scrambled so stale data never matches
   task automatic issue(input logic [CA_W-1:0] ca, input logic bad, input int lat);
      @(posedge clk);
      pins.cs_n <= 1'b0;
      pins.ca <= ca;
      pins.par <= ^ca ^ bad;
      @(posedge clk);
      pins.cs_n <= 1'b1;
      repeat (lat) @(posedge clk);
      pins.ca <= ~ca;
      pins.par <= ~pins.par;
   endtask
   task automatic ct_enter(input logic [CA_W-1:0] ca);
      @(posedge clk);
      pins.ten <= 1'b1;
      pins.cke <= 1'b0;
      repeat (CT_ENABLE_CYC + 2) @(posedge clk);
      pins.cke <= 1'b1;
      pins.cs_n <= 1'b0;
      pins.ca <= ca;
   endtask
endmodule

// >>> tb/dacm_core_tb_top.sv
`timescale 1ns/1ns
module dacm_core_tb_top import dacm_pkg::*;;
   localparam int G = 0;
   localparam int TCP = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic [31:0] prdata;
   logic pready, pslverr, irq, alert_n, ct_out, err;
   dacm_pins_s pins;
   dacm_cmd_s cmd;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int t0, lat0;
   // clock never stops, power saving included
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   dacm_core #(.GRADE(G), .TCPDED_CK(TCP)) dacm_core_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .irq(irq), .pins(pins), .alert_n(alert_n),
      .ct_out(ct_out), .cmd(cmd));
   dacm_ctl_model dacm_ctl_model_i (.clk(clk), .pins(pins));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no cycle count assumed: only the watchdog ends a hung transfer
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic wait_cmd(input int lim);
      int n = 0;
      while (cmd.valid !== 1'b1 && n < lim) begin
         n++;
         @(posedge clk);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(100 * 5000);
      n_errors++;
      end_of_test;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rchk("ctrl", CTRL_OFS, 32'(CTRL_RST));
      rchk("stat", STAT_OFS, 32'h0);
      rchk("imsk", IMSK_OFS, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      t0 = cyc;
      dacm_ctl_model_i.issue(24'hA5C3E1, 1'b0, 0);
      wait_cmd(10);
      lat0 = cyc - t0;
      chk("cmd lat", 32'h5, 32'(lat0));
      chk("cmd ca", 32'h00A5C3E1, 32'(cmd.ca));
      rchk("lcmd", LCMD_OFS, 32'h00A5C3E1);
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, CTRL_OFS, m ? 32'h07 : 32'h05);
         t0 = cyc;
         dacm_ctl_model_i.issue(24'h13579B, 1'b0, m ? CALG_TAB[G] : CAL_TAB[G]);
         wait_cmd(20);
         chk("cal lat", 32'(lat0 + (m ? CALG_TAB[G] : CAL_TAB[G])), 32'(cyc - t0));
      end
      apb(1'b1, CTRL_OFS, 32'h04);
      dacm_ctl_model_i.issue(24'h0F0F0F, 1'b1, 0);
      t0 = cyc;
      while (alert_n !== 1'b0 && cyc - t0 < 20) @(posedge clk);
      chk("alert delay", 32'(PL_TAB[G] + 2), 32'(cyc - t0));
      t0 = cyc;
      // only deselects follow the alert
      while (alert_n === 1'b0 && cyc - t0 < 300) @(posedge clk);
      chk("alert width", 32'(ALERT_PW_MIN_TAB[G]), 32'(cyc - t0));
      chk("irq masked", 32'h0, 32'(irq));
      rchk("ist par", IST_OFS, 32'h1);
      rchk("ctrl par off", CTRL_OFS, 32'h0);
      apb(1'b1, IMSK_OFS, 32'h07);
      @(posedge clk);
      chk("irq on", 32'h1, 32'(irq));
      apb(1'b1, IST_OFS, 32'h1);
      @(posedge clk);
      chk("irq off", 32'h0, 32'(irq));
      apb(1'b1, CTRL_OFS, 32'h0C);
      dacm_ctl_model_i.issue(24'h0F0F0F, 1'b1, 0);
      t0 = cyc;
      while (alert_n !== 1'b0 && cyc - t0 < 20) @(posedge clk);
      chk("pers alert delay", 32'(PL_TAB[G] + 2), 32'(cyc - t0));
      rchk("ctrl pers", CTRL_OFS, 32'h0C);
      while (alert_n === 1'b0 && cyc - t0 < 300) @(posedge clk);
      chk("pers alert end", 32'h1, 32'(alert_n));
      apb(1'b1, IST_OFS, 32'h1);
      apb(1'b1, CTRL_OFS, 32'h14);
      rchk("path on", STAT_OFS, 32'h0);
      repeat (TMOD_CYC + TCP) @(posedge clk);
      rchk("path off", STAT_OFS, 32'h2);
      dacm_ctl_model_i.issue(24'h111111, 1'b0, 0);
      wait_cmd(8);
      chk("no cmd", 32'h0, 32'(cmd.valid));
      apb(1'b1, CTRL_OFS, 32'h04);
      rchk("ist mpsm", IST_OFS, 32'h2);
      repeat (20) @(posedge clk);
      dacm_ctl_model_i.issue(24'h222222, 1'b0, 0);
      wait_cmd(10);
      chk("cmd after exit", 32'h00222222, 32'(cmd.ca));
      dacm_ctl_model_i.ct_enter(24'h000001);
      t0 = cyc;
      while (ct_out !== 1'b1 && cyc - t0 < CT_VALID_CYC + 4) @(posedge clk);
      chk("ct out", 32'h1, 32'(ct_out));
      rchk("ct stat", STAT_OFS, 32'h4);
      end_of_test;
   end
endmodule
